// file: inc/etr_pkg.sv
// package of constants for the edge toggle data recovery block
// How it works
// [RQ1] detector idles high, pulses low per transition
// [RQ2] toggle register flips on detector falling edge
// [RQ3] transmit forces true low, complement high
// [RQ4] inverted enable holds register clear while driving
// [RQ5] controller enables receiver to release clear
// [RQ6] line driver only transmits; reception via detector
// [RQ7] plain serial data, no framing or coding
// [RQ8] receiver picks true or complement by ordering
`default_nettype none
package etr_pkg;
  localparam int          ETR_FIFO_WIDTH = 2;      // true and complement pair
  localparam int          ETR_FIFO_DEPTH = 8;      // words buffered
  localparam logic        ETR_DET_IDLE   = 1'h1;   // detector level when idle
  localparam logic        ETR_Q_RESET    = 1'h0;   // true output after clear
  localparam logic [1:0]  ETR_SYNC_RESET = 2'h0;   // synchroniser reset value
  typedef enum logic [1:0] {ETR_TRANSMIT, ETR_RECEIVE} etr_mode_t;
endpackage
`default_nettype wire

// file: inc/etr_stream_if.sv
// interface carrying the recovered data stream into and out of the fifo
`default_nettype none
interface etr_stream_if #(parameter int WIDTH = 2);
  logic             valid;  // word offered
  logic             ready;  // word accepted
  logic [WIDTH-1:0] data;   // word
  modport src  (output valid, output data, input ready);
  modport sink (input valid, input data, output ready);
endinterface
`default_nettype wire

// file: src/etr_fifo.sv
// small flip-flop fifo with valid and ready on both sides
`default_nettype none
module etr_fifo
  import etr_pkg::*;
#(
  parameter int WIDTH = ETR_FIFO_WIDTH,
  parameter int DEPTH = ETR_FIFO_DEPTH
) (
  input  wire logic clk_in,
  input  wire logic rst_in,
  input  wire logic ce_in,
  etr_stream_if.sink wr,
  etr_stream_if.src  rd
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];  // storage
  logic [AW-1:0]    wp;           // write index
  logic [AW-1:0]    rp;           // read index
  logic [AW:0]      cnt;          // fill level
  wire              do_wr = wr.valid && wr.ready;
  wire              do_rd = rd.valid && rd.ready;
  assign wr.ready = (cnt != (AW+1)'(DEPTH));
  assign rd.valid = (cnt != '0);
  assign rd.data  = mem[rp];
  //////////////////////////////////////////////////////////////////////
  // storage entries, one per generate slot
  for (genvar i = 0; i < DEPTH; i++) begin : g_ent
    always_ff @(posedge clk_in) begin
      if (ce_in && do_wr && wp == AW'(i)) begin
        mem[i] <= wr.data;
      end
    end
  end
  // pointers and level
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      wp  <= '0;
      rp  <= '0;
      cnt <= '0;
    end else if (ce_in) begin
      if (do_wr) wp <= (wp == AW'(DEPTH-1)) ? '0 : wp + 1'b1;
      if (do_rd) rp <= (rp == AW'(DEPTH-1)) ? '0 : rp + 1'b1;
      cnt <= cnt + (AW+1)'(do_wr) - (AW+1)'(do_rd);
    end
  end
  // level never passes the depth
  property p_no_overflow;
    @(posedge clk_in) disable iff (rst_in)
      cnt <= (AW+1)'(DEPTH);
  endproperty
  a_no_overflow: assert property (p_no_overflow) else $error("fifo level above depth");
endmodule
`default_nettype wire

// file: src/etr_top.sv
// receive data recovery: edge detector, toggle register and output fifo
`default_nettype none
module etr_top
  import etr_pkg::*;
(
  input  wire logic CLK_IN,            // 20 MHz clock
  input  wire logic SYS_RST_IN,        // synchronous reset, high
  input  wire logic CE_IN,             // clock enable, freezes all state
  input  wire logic TX_DATA_IN,        // serial data from controller
  input  wire logic DRV_EN_IN,         // shared driver/receiver enable
  input  wire logic BUS_LEVEL_IN,      // sensed bus level, from pin
  input  wire logic RX_READY_IN,       // controller takes recovered word
  output logic      LINE_DATA_OUT,     // data to line driver
  output logic      LINE_DRV_EN_OUT,   // line driver enable
  output logic      EDGE_N_OUT,        // detector output, low on edge
  output logic      RX_Q_OUT,          // recovered true output
  output logic      RX_QN_OUT,         // recovered complement output
  output logic      RX_VALID_OUT,      // recovered word waiting
  output logic      RX_WORD_Q_OUT,     // buffered true output
  output logic      RX_WORD_QN_OUT     // buffered complement output
);
  //////////////////////////////////////////////////////////////////////
  // synchronisers on pin inputs
  logic [1:0] bus_sync;   // bus level stages
  logic [1:0] en_sync;    // enable stages
  logic       bus_prev;   // last synchronised bus level
  logic       edge_n;     // detector state, active low
  logic       edge_n_d;   // detector one cycle back
  logic       q;          // toggle register true output
  etr_mode_t  mode;       // transmit or receive
  wire        bus_s   = bus_sync[1];
  wire        drv_s   = en_sync[1];
  wire        clr     = ~(~drv_s);                 // inverted receive enable clear
  wire        next_edge_n = ~(bus_s ^ bus_prev);   // low for any direction
  wire        fall    = edge_n_d & ~edge_n;         // detector falling edge
  wire        next_q  = clr ? ETR_Q_RESET : (fall ? ~q : q);
  etr_stream_if #(.WIDTH(ETR_FIFO_WIDTH)) s_in ();
  etr_stream_if #(.WIDTH(ETR_FIFO_WIDTH)) s_out ();
  // second stage only reads the first
  always_ff @(posedge CLK_IN) begin
    if (SYS_RST_IN) begin
      bus_sync <= ETR_SYNC_RESET;
      en_sync  <= ETR_SYNC_RESET;
    end else if (CE_IN) begin
      bus_sync <= {bus_sync[0], BUS_LEVEL_IN};
      en_sync  <= {en_sync[0], DRV_EN_IN};
    end
  end
  //////////////////////////////////////////////////////////////////////
  // edge detector, idles high
  always_ff @(posedge CLK_IN) begin
    if (SYS_RST_IN) begin
      bus_prev <= 1'h0;
      edge_n   <= ETR_DET_IDLE;
      edge_n_d <= ETR_DET_IDLE;
    end else if (CE_IN) begin
      bus_prev <= bus_s;
      edge_n   <= next_edge_n;  // see RQ1
      edge_n_d <= edge_n;
    end
  end
  // toggle register, cleared while node drives
  always_ff @(posedge CLK_IN) begin
    if (SYS_RST_IN) begin
      q    <= ETR_Q_RESET;
      mode <= ETR_RECEIVE;
    end else if (CE_IN) begin
      q    <= next_q;  // see RQ2, see RQ3, see RQ4
      mode <= drv_s ? ETR_TRANSMIT : ETR_RECEIVE;  // see RQ5
    end
  end
  //////////////////////////////////////////////////////////////////////
  // fifo feed: push each recovered change while the fifo is not full, only while receiving
  assign s_in.valid = (mode == ETR_RECEIVE) && !clr && fall;
  assign s_in.data  = {~next_q, next_q};
  assign s_out.ready = RX_READY_IN && RX_VALID_OUT;
  etr_fifo #(.WIDTH(ETR_FIFO_WIDTH), .DEPTH(ETR_FIFO_DEPTH)) u_fifo (
    .clk_in (CLK_IN),
    .rst_in (SYS_RST_IN),
    .ce_in  (CE_IN),
    .wr     (s_in),
    .rd     (s_out)
  );
  //////////////////////////////////////////////////////////////////////
  // registered outputs; driver path carries raw data only
  always_ff @(posedge CLK_IN) begin
    if (SYS_RST_IN) begin
      LINE_DATA_OUT   <= 1'h0;
      LINE_DRV_EN_OUT <= 1'h0;
      EDGE_N_OUT      <= ETR_DET_IDLE;
      RX_Q_OUT        <= ETR_Q_RESET;
      RX_QN_OUT       <= ~ETR_Q_RESET;
      RX_VALID_OUT    <= 1'h0;
      RX_WORD_Q_OUT   <= ETR_Q_RESET;
      RX_WORD_QN_OUT  <= ~ETR_Q_RESET;
    end else if (CE_IN) begin
      LINE_DATA_OUT   <= TX_DATA_IN;   // see RQ6, see RQ7
      LINE_DRV_EN_OUT <= DRV_EN_IN;    // see RQ6
      EDGE_N_OUT      <= edge_n;
      RX_Q_OUT        <= q;            // see RQ8
      RX_QN_OUT       <= ~q;
      RX_VALID_OUT    <= s_out.valid && !(s_out.ready && RX_VALID_OUT);
      if (s_out.valid) begin
        RX_WORD_Q_OUT  <= s_out.data[0];
        RX_WORD_QN_OUT <= s_out.data[1];
      end
    end
  end
  //////////////////////////////////////////////////////////////////////
  // checks
  property p_idle_high;
    @(posedge CLK_IN) disable iff (SYS_RST_IN)
      (CE_IN && $stable(bus_s)) |=> edge_n;
  endproperty
  a_idle_high: assert property (p_idle_high) else $error("detector low without edge"); // see RQ1
  property p_edge_low;
    @(posedge CLK_IN) disable iff (SYS_RST_IN)
      (CE_IN && (bus_s != bus_prev)) |=> !edge_n;
  endproperty
  a_edge_low: assert property (p_edge_low) else $error("edge missed"); // see RQ1
  property p_toggle;
    @(posedge CLK_IN) disable iff (SYS_RST_IN)
      (CE_IN && fall && !clr) |=> (q != $past(q));
  endproperty
  a_toggle: assert property (p_toggle) else $error("no toggle on falling edge"); // see RQ2
  property p_hold;
    @(posedge CLK_IN) disable iff (SYS_RST_IN)
      (CE_IN && !fall && !clr) |=> (q == $past(q));
  endproperty
  a_hold: assert property (p_hold) else $error("toggle without edge"); // see RQ2
  property p_clear;
    @(posedge CLK_IN) disable iff (SYS_RST_IN)
      (CE_IN && clr) |=> !q;
  endproperty
  a_clear: assert property (p_clear) else $error("not cleared while driving"); // see RQ4
  property p_clear_out;
    @(posedge CLK_IN) disable iff (SYS_RST_IN)
      (CE_IN && clr) ##1 CE_IN |=> (!RX_Q_OUT && RX_QN_OUT);
  endproperty
  a_clear_out: assert property (p_clear_out) else $error("outputs not in initial state"); // see RQ3
  property p_compl;
    @(posedge CLK_IN) disable iff (SYS_RST_IN)
      RX_Q_OUT != RX_QN_OUT;
  endproperty
  a_compl: assert property (p_compl) else $error("outputs not complementary"); // see RQ8
  property p_passthru;
    @(posedge CLK_IN) disable iff (SYS_RST_IN)
      CE_IN |=> (LINE_DATA_OUT == $past(TX_DATA_IN));
  endproperty
  a_passthru: assert property (p_passthru) else $error("driver data altered"); // see RQ7
  property p_drv_en;
    @(posedge CLK_IN) disable iff (SYS_RST_IN)
      CE_IN |=> (LINE_DRV_EN_OUT == $past(DRV_EN_IN));
  endproperty
  a_drv_en: assert property (p_drv_en) else $error("driver enable altered"); // see RQ6
  c_toggle: cover property (@(posedge CLK_IN) fall && !clr);
  c_release: cover property (@(posedge CLK_IN) clr ##1 !clr);
  c_full: cover property (@(posedge CLK_IN) !s_in.ready);
endmodule
`default_nettype wire

// file: dv/etr_node_model.sv
// behavioural model of a remote node sharing the bus with the block
`default_nettype none
module etr_node_model (
  input  wire logic clk_in,      // bench clock
  input  wire logic bit_in,      // remote node serial data
  input  wire logic drv_en_in,   // local line driver enable
  input  wire logic drv_data_in, // local line driver data
  output logic      bus_out      // level sensed on the bus
);
  timeunit 1ns;
  timeprecision 1ps;
  // local driver wins while enabled, else remote sends plain bits
  always_ff @(posedge clk_in) begin
    bus_out <= drv_en_in ? drv_data_in : bit_in;
  end
endmodule
`default_nettype wire

// file: dv/etr_top_tb.sv
// self-checking bench for the edge toggle data recovery block
`default_nettype none
module etr_top_tb
  import etr_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam time DLY = 5ns;                      // drive offset after edge
  typedef struct {logic b; logic [7:0] e;} etr_row_t; // bit, edge pulses
  logic     clk = 1'h0, rst = 1'h1, drv_en = 1'h0; // clock, reset, enable
  logic     tx = 1'h0, rdy = 1'h0, rbit = 1'h0;    // stimulus
  logic     ce = 1'h1;                             // clock enable
  logic     bus, ld, lde, edge_n, q, qn, vld, wq, wqn; // observed
  int       fails = 0, num_checks = 0, words;      // counters
  logic [7:0] edges;                               // pulses in window
  etr_row_t rows [12] = '{'{1'h1,8'h1}, '{1'h1,8'h0}, '{1'h0,8'h1}, '{1'h1,8'h1},
    '{1'h0,8'h1}, '{1'h0,8'h0}, '{1'h1,8'h1}, '{1'h0,8'h1}, '{1'h1,8'h1},
    '{1'h0,8'h1}, '{1'h1,8'h1}, '{1'h0,8'h1}};
  etr_top dut (.CLK_IN(clk), .SYS_RST_IN(rst), .CE_IN(ce), .TX_DATA_IN(tx),
    .DRV_EN_IN(drv_en), .BUS_LEVEL_IN(bus), .RX_READY_IN(rdy), .LINE_DATA_OUT(ld),
    .LINE_DRV_EN_OUT(lde), .EDGE_N_OUT(edge_n), .RX_Q_OUT(q), .RX_QN_OUT(qn),
    .RX_VALID_OUT(vld), .RX_WORD_Q_OUT(wq), .RX_WORD_QN_OUT(wqn));
  etr_node_model node (.clk_in(clk), .bit_in(rbit), .drv_en_in(lde),
    .drv_data_in(ld), .bus_out(bus));
  ////////////////////////////////////////////////////////////////////////////
  // compare one value and count it
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH %s expected %0h seen %0h", what, exp, got);
    end
  endtask
  // run n cycles, counting detector pulses
  task automatic step(input int n);
    edges = 8'h0;
    repeat (n) begin
      @(posedge clk);
      #DLY;
      if (edge_n === 1'h0) edges++;
    end
  endtask
  // print counts and verdict, then stop
  task automatic final_report();
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // clock and watchdog
  always #25ns clk = ~clk;
  initial begin
    #(4000 * 50ns);
    fails++;
    final_report();
  end
  // main sequence
  initial begin
    repeat (8) @(posedge clk);
    #DLY rst = 1'h0;
    chk("edge_n", ETR_DET_IDLE, edge_n);
    chk("rx_q", ETR_Q_RESET, q);
    chk("rx_qn", {7'h0, ~ETR_Q_RESET}, qn);
    chk("valid", 8'h0, vld);
    $display("test reset done");
    // table of bits sent by the remote node, consumer stalled
    foreach (rows[i]) begin
      rbit = rows[i].b;
      step(8);
      chk("edges", rows[i].e, edges);
      chk("rx_q", rows[i].b, q);
      chk("rx_qn", {7'h0, ~rows[i].b}, qn);
    end
    $display("test table done");
    // drain the full buffer, extra toggles were refused
    rdy = 1'h1;
    words = 0;
    repeat (20) begin
      @(negedge clk);
      if (vld === 1'h1) begin
        chk("word_q", words[0] ? 8'h0 : 8'h1, wq);
        chk("word_qn", words[0] ? 8'h1 : 8'h0, wqn);
        words++;
      end
    end
    chk("words", 8'(ETR_FIFO_DEPTH), 8'(words));
    $display("test buffer done");
    // transmit clears a set register and blocks toggling
    @(posedge clk);
    #DLY rbit = 1'h1;
    step(8);
    chk("rx_q", 8'h1, q);
    drv_en = 1'h1;
    tx = 1'h0;
    step(6);
    chk("drv_en", 8'h1, lde);
    chk("rx_q", 8'h0, q);
    chk("rx_qn", 8'h1, qn);
    tx = 1'h1;
    step(6);
    chk("line", 8'h1, ld);
    chk("rx_q", 8'h0, q);
    drv_en = 1'h0;
    step(8);
    chk("rx_q", 8'h0, q);
    rbit = 1'h0;
    step(8);
    chk("rx_q", 8'h1, q);
    chk("rx_qn", 8'h0, qn);
    $display("test transmit done");
    // clock enable low freezes the register, release lets the edge through
    ce = 1'h0;
    rbit = 1'h1;
    step(8);
    chk("rx_q", 8'h1, q);
    ce = 1'h1;
    step(8);
    chk("rx_q", 8'h0, q);
    $display("test enable done");
    final_report();
  end
endmodule
`default_nettype wire
